// ===== ccs_clock_select.sv
// Behaviour
// [RULE_01] Request register holds source in bits 6:4.
// [RULE_02] Decode five sources; three codes reserved.
// [RULE_03] Request register holds divider in bits 3:0.
// [RULE_04] Divide by two to the divider code.
// [RULE_05] Reserved source write leaves source field unchanged.
// [RULE_06] Switch disallowed: request register stays read-only.
// [RULE_07] Reset source config sets request reset values.
// [RULE_08] Fast oscillator preset 64 or 4 MHz.
// [RULE_09] Status register reports active source bits 6:4.
// [RULE_10] Status register reports active divider bits 3:0.
// [RULE_11] Active fields start equal to request fields.
// [RULE_12] Oscillator registers sit at indexes 0xED3 to 0xED9.
// [RULE_13] Keep present clock until requested clock ready.
// [RULE_14] Hold bit suspends switch; abandon by copying back.
// [RULE_15] Switch updates active fields, done flag, ready flag.
// [RULE_16] Active fields read-only; bit seven reads zero.
`timescale 1ns/10ps
`default_nettype none
module ccs_clock_select #(
	parameter int unsigned INIT_WAIT = 2
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [2:0] reset_source_cfg,
	input wire logic switch_allow_cfg,
	input wire logic [7:0] osc_ready,
	output ccs_pkg::ccs_clk_sel_t sys_clk_sel,
	output logic [9:0] postscale_ratio,
	output logic [7:0] osc_manual_enable,
	output logic [ccs_pkg::TUNE_W-1:0] fast_osc_tune,
	output logic [ccs_pkg::FRQ_W-1:0] fast_osc_freq_field,
	output logic secondary_osc_high_power,
	output logic irq
);

	localparam logic [1:0] INIT_W = 2'(INIT_WAIT);

	// The synchroniser needs two edges before the straps can be trusted.
	if (INIT_WAIT < 2 || INIT_WAIT > 3) begin : g_bad_wait
		$error("INIT_WAIT must be 2 or 3");
	end

	ccs_pkg::ccs_state_t s_q;
	ccs_pkg::ccs_state_t s_d;

	function automatic logic src_valid(input logic [2:0] src);
		src_valid = (src == ccs_pkg::SRC_EXT) || (src == ccs_pkg::SRC_FAST) ||
			(src == ccs_pkg::SRC_SLOW) || (src == ccs_pkg::SRC_SEC) ||
			(src == ccs_pkg::SRC_PLL); // [RULE_02]
	endfunction

	// A source already driving the system is ready at once, which makes a
	// divider-only change complete without waiting on any oscillator.
	function automatic logic src_ready(input logic [2:0] src, input logic [2:0] cur,
		input logic [7:0] rdy);
		if (src == cur) begin
			src_ready = 1'b1;
		end else if (src == ccs_pkg::SRC_EXT) begin
			src_ready = rdy[ccs_pkg::RDY_EXT];
		end else if (src == ccs_pkg::SRC_FAST) begin
			src_ready = rdy[ccs_pkg::RDY_FAST];
		end else if (src == ccs_pkg::SRC_SLOW) begin
			src_ready = rdy[ccs_pkg::RDY_SLOW];
		end else if (src == ccs_pkg::SRC_SEC) begin
			src_ready = rdy[ccs_pkg::RDY_SEC];
		end else if (src == ccs_pkg::SRC_PLL) begin
			src_ready = rdy[ccs_pkg::RDY_PLL];
		end else begin
			src_ready = 1'b0;
		end
	endfunction

	function automatic ccs_pkg::ccs_clk_sel_t reset_sel(input logic [2:0] cfg);
		reset_sel = '0;
		reset_sel.div = ccs_pkg::DIV_ONE;
		if (cfg == ccs_pkg::CFG_FAST64) begin
			reset_sel.src = ccs_pkg::SRC_FAST; // [RULE_07]
		end else if (cfg == ccs_pkg::SRC_FAST) begin
			reset_sel.src = ccs_pkg::SRC_FAST;
			reset_sel.div = ccs_pkg::DIV_FOUR; // [RULE_07]
		end else if (src_valid(cfg)) begin
			reset_sel.src = cfg; // [RULE_07]
		end else begin
			// Reserved strap codes fall back to the fast oscillator.
			reset_sel.src = ccs_pkg::SRC_FAST;
		end
	endfunction

	function automatic logic [9:0] ratio_of(input logic [3:0] div);
		ratio_of = ccs_pkg::RATIO_ONE << div; // [RULE_04]
	endfunction

	function automatic logic [7:0] rd_byte(input ccs_pkg::ccs_state_t st,
		input logic [29:0] a);
		ccs_pkg::ccs_ctrl_t c;
		c = '0;
		c.hold = st.hold;
		c.spwr = st.spwr;
		c.done = st.done;
		c.nrdy = st.nrdy;
		rd_byte = 8'h00;
		if (a == ccs_pkg::IDX_REQ) begin // [RULE_12]
			rd_byte = {1'b0, st.req.src, st.req.div}; // [RULE_16]
		end else if (a == ccs_pkg::IDX_ACT) begin
			rd_byte = {1'b0, st.act.src, st.act.div}; // [RULE_09] [RULE_10]
		end else if (a == ccs_pkg::IDX_CTRL) begin
			rd_byte = c;
		end else if (a == ccs_pkg::IDX_RDY) begin
			rd_byte = st.rdy_s2 & ccs_pkg::RDY_MASK;
		end else if (a == ccs_pkg::IDX_OSC_MANUAL_ENABLE) begin
			rd_byte = st.osc_en;
		end else if (a == ccs_pkg::IDX_TUNE) begin
			rd_byte = 8'(st.tune);
		end else if (a == ccs_pkg::IDX_FRQ) begin
			rd_byte = 8'(st.frq);
		end else if (a == ccs_pkg::IDX_STS) begin
			rd_byte = 8'(st.sts);
		end else if (a == ccs_pkg::IDX_MSK) begin
			rd_byte = 8'(st.msk);
		end
	endfunction

	always_comb begin
		logic take;
		logic ev_sw;
		logic ev_rej;
		logic [7:0] wb;
		ccs_pkg::ccs_clk_sel_t wsel;
		ccs_pkg::ccs_ctrl_t wc;
		logic [ccs_pkg::IRQ_W-1:0] clr;
		logic [ccs_pkg::IRQ_W-1:0] ev;
		take = 1'b0;
		ev_sw = 1'b0;
		ev_rej = 1'b0;
		wb = hwdata[7:0];
		wsel = wb;
		wc = wb;
		clr = '0;
		ev = '0;
		s_d = s_q;
		s_d.cfg_s1 = reset_source_cfg;
		s_d.cfg_s2 = s_q.cfg_s1;
		s_d.allow_s1 = switch_allow_cfg;
		s_d.allow_s2 = s_q.allow_s1;
		s_d.rdy_s1 = osc_ready;
		s_d.rdy_s2 = s_q.rdy_s1;

		// Bus address phase. Reads take one wait state so that a write in the
		// preceding data phase is already visible to them.
		take = hsel && htrans[1] && hready;
		s_d.wr_pend = take && hwrite;
		s_d.rd_pend = take && !hwrite;
		s_d.ready = !(take && !hwrite);
		if (take) begin
			s_d.addr = haddr[31:2];
		end
		if (s_q.rd_pend) begin
			s_d.rdata = {24'h00_0000, rd_byte(s_q, s_q.addr)};
		end

		case (s_q.fsm)
			ccs_pkg::ST_INIT: begin
				if (s_q.init_cnt != INIT_W) begin
					s_d.init_cnt = s_q.init_cnt + 2'h1;
				end else begin
					s_d.req = reset_sel(s_q.cfg_s2); // [RULE_07]
					s_d.act = s_d.req; // [RULE_11]
					s_d.frq = (s_q.cfg_s2 == ccs_pkg::CFG_FAST64) ?
						ccs_pkg::FRQ_64MHZ : ccs_pkg::FRQ_4MHZ; // [RULE_08]
					s_d.fsm = ccs_pkg::ST_IDLE;
				end
			end
			ccs_pkg::ST_IDLE: begin
				if (s_q.req != s_q.act) begin
					s_d.fsm = ccs_pkg::ST_WAIT; // [RULE_13]
				end
			end
			ccs_pkg::ST_WAIT: begin
				if (s_q.req == s_q.act) begin
					s_d.fsm = ccs_pkg::ST_IDLE;
				end else if (src_ready(s_q.req.src, s_q.act.src, s_q.rdy_s2)) begin
					s_d.nrdy = 1'b1;
					ev_sw = 1'b1;
					s_d.fsm = ccs_pkg::ST_READY;
				end
			end
			ccs_pkg::ST_READY: begin
				if (s_q.req == s_q.act) begin
					s_d.nrdy = 1'b0; // [RULE_14]
					s_d.fsm = ccs_pkg::ST_IDLE;
				end else if (!src_ready(s_q.req.src, s_q.act.src, s_q.rdy_s2)) begin
					// The request moved to an oscillator that is not up yet.
					s_d.nrdy = 1'b0;
					s_d.fsm = ccs_pkg::ST_WAIT;
				end else if (!s_q.hold) begin
					s_d.act = s_q.req; // [RULE_15]
					s_d.nrdy = 1'b0; // [RULE_15]
					s_d.fsm = ccs_pkg::ST_IDLE;
				end
			end
			default: begin
				s_d.fsm = ccs_pkg::ST_IDLE;
			end
		endcase

		// Data phase of a write. The active register has no write path.
		if (s_q.wr_pend && s_q.fsm != ccs_pkg::ST_INIT) begin
			if (s_q.addr == ccs_pkg::IDX_REQ) begin
				if (s_q.allow_s2) begin // [RULE_06]
					if (!src_valid(wsel.src)) begin
						// A reserved source drops the whole write, divider too.
						ev_rej = 1'b1; // [RULE_05]
					end else begin
						s_d.req.src = wsel.src; // [RULE_01]
						if (wsel.div <= ccs_pkg::DIV_MAX) begin
							s_d.req.div = wsel.div; // [RULE_03]
						end else begin
							ev_rej = 1'b1; // [RULE_04]
						end
					end
				end
			end else if (s_q.addr == ccs_pkg::IDX_CTRL) begin
				s_d.hold = wc.hold; // [RULE_14]
				s_d.spwr = wc.spwr;
			end else if (s_q.addr == ccs_pkg::IDX_OSC_MANUAL_ENABLE) begin
				s_d.osc_en = wb & ccs_pkg::OSC_MANUAL_ENABLE_MASK;
			end else if (s_q.addr == ccs_pkg::IDX_TUNE) begin
				s_d.tune = wb[ccs_pkg::TUNE_W-1:0];
			end else if (s_q.addr == ccs_pkg::IDX_FRQ) begin
				s_d.frq = wb[ccs_pkg::FRQ_W-1:0];
			end else if (s_q.addr == ccs_pkg::IDX_STS) begin
				clr = wb[ccs_pkg::IRQ_W-1:0];
			end else if (s_q.addr == ccs_pkg::IDX_MSK) begin
				s_d.msk = wb[ccs_pkg::IRQ_W-1:0];
			end
		end

		// A new event in the same cycle as its clear keeps the bit set.
		ev[ccs_pkg::IRQ_SWITCH] = ev_sw;
		ev[ccs_pkg::IRQ_REJECT] = ev_rej;
		s_d.sts = (s_q.sts & ~clr) | ev;
		s_d.irq = |(s_d.sts & s_d.msk);
		s_d.done = (s_d.req == s_d.act) && (s_d.fsm != ccs_pkg::ST_INIT); // [RULE_15]
		s_d.ratio = ratio_of(s_d.act.div);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= ccs_pkg::STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign hrdata = s_q.rdata;
	assign hreadyout = s_q.ready;
	assign hresp = 1'b0;
	assign sys_clk_sel = s_q.act;
	assign postscale_ratio = s_q.ratio;
	assign osc_manual_enable = s_q.osc_en;
	assign fast_osc_tune = s_q.tune;
	assign fast_osc_freq_field = s_q.frq;
	assign secondary_osc_high_power = s_q.spwr;
	assign irq = s_q.irq;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	chk_src_write: assert property ( // [RULE_01]
		s_q.wr_pend && s_q.addr == ccs_pkg::IDX_REQ && s_q.allow_s2 &&
		s_q.fsm != ccs_pkg::ST_INIT && src_valid(hwdata[6:4])
		|=> s_q.req.src == $past(hwdata[6:4]))
		else $error("requested source not stored");

	chk_div_write: assert property ( // [RULE_03]
		s_q.wr_pend && s_q.addr == ccs_pkg::IDX_REQ && s_q.allow_s2 &&
		s_q.fsm != ccs_pkg::ST_INIT && hwdata[3:0] <= ccs_pkg::DIV_MAX &&
		src_valid(hwdata[6:4])
		|=> s_q.req.div == $past(hwdata[3:0]))
		else $error("requested divider not stored");

	chk_reserved_src: assert property ( // [RULE_05]
		s_q.wr_pend && s_q.addr == ccs_pkg::IDX_REQ && s_q.allow_s2 &&
		s_q.fsm != ccs_pkg::ST_INIT && !src_valid(hwdata[6:4])
		|=> $stable(s_q.req) && s_q.sts[ccs_pkg::IRQ_REJECT])
		else $error("reserved source write was not dropped");

	chk_locked_req: assert property ( // [RULE_06]
		s_q.fsm != ccs_pkg::ST_INIT && !s_q.allow_s2 |=> $stable(s_q.req))
		else $error("request changed while switching is disallowed");

	chk_ratio_pow2: assert property ( // [RULE_04]
		s_q.fsm != ccs_pkg::ST_INIT |-> s_q.ratio == (ccs_pkg::RATIO_ONE << s_q.act.div))
		else $error("postscale ratio does not match active divider");

	chk_reset_load: assert property ( // [RULE_11]
		s_q.fsm == ccs_pkg::ST_INIT && s_q.init_cnt == INIT_W
		|=> s_q.act == s_q.req && s_q.fsm == ccs_pkg::ST_IDLE && s_q.done)
		else $error("active fields differ from request after reset");

	chk_hold_keeps: assert property ( // [RULE_14]
		s_q.fsm == ccs_pkg::ST_READY && s_q.hold |=> $stable(s_q.act))
		else $error("active clock changed while hold is set");

	chk_switch_update: assert property ( // [RULE_15]
		s_q.fsm == ccs_pkg::ST_READY && !s_q.hold && s_q.req != s_q.act &&
		!(s_q.wr_pend && s_q.addr == ccs_pkg::IDX_REQ) &&
		src_ready(s_q.req.src, s_q.act.src, s_q.rdy_s2)
		|=> s_q.act == $past(s_q.req) && !s_q.nrdy && s_q.done)
		else $error("switch did not update active fields and flags");

	chk_no_early_sw: assert property ( // [RULE_13]
		s_q.fsm != ccs_pkg::ST_INIT && $past(s_q.fsm) != ccs_pkg::ST_INIT &&
		$changed(s_q.act) |-> $past(s_q.fsm) == ccs_pkg::ST_READY)
		else $error("active clock changed before new source was ready");

	chk_bit7_zero: assert property ( // [RULE_16]
		s_q.rd_pend |=> s_q.rdata[31:7] == 25'h000_0000 || s_q.addr == ccs_pkg::IDX_CTRL ||
		s_q.addr == ccs_pkg::IDX_RDY || s_q.addr == ccs_pkg::IDX_OSC_MANUAL_ENABLE)
		else $error("unused upper read bits not zero");

	chk_fast_preset: assert property ( // [RULE_08]
		s_q.fsm == ccs_pkg::ST_INIT && s_q.init_cnt == INIT_W &&
		s_q.cfg_s2 == ccs_pkg::CFG_FAST64 |=> s_q.frq == ccs_pkg::FRQ_64MHZ)
		else $error("fast oscillator not preset to 64 MHz");

	chk_div_reserved: assert property ( // [RULE_04]
		s_q.wr_pend && s_q.addr == ccs_pkg::IDX_REQ && s_q.allow_s2 &&
		s_q.fsm != ccs_pkg::ST_INIT && hwdata[3:0] > ccs_pkg::DIV_MAX
		|=> $stable(s_q.req.div) && s_q.sts[ccs_pkg::IRQ_REJECT])
		else $error("reserved divider code was stored");

	chk_read_wait: assert property ( // [RULE_12]
		s_q.rd_pend |-> !hreadyout ##1 hreadyout)
		else $error("read data phase did not take exactly one wait state");

	chk_req_readback: assert property ( // [RULE_12] [RULE_16]
		s_q.rd_pend && s_q.addr == ccs_pkg::IDX_REQ
		|=> s_q.rdata == {25'h000_0000, $past(s_q.req.src), $past(s_q.req.div)})
		else $error("request register read back wrong");

	chk_act_readback: assert property ( // [RULE_09] [RULE_10]
		s_q.rd_pend && s_q.addr == ccs_pkg::IDX_ACT
		|=> s_q.rdata == {25'h000_0000, $past(s_q.act.src), $past(s_q.act.div)})
		else $error("active register read back wrong");

	chk_act_no_write: assert property ( // [RULE_16]
		s_q.wr_pend && s_q.addr == ccs_pkg::IDX_ACT && s_q.fsm == ccs_pkg::ST_IDLE
		|=> $stable(s_q.act))
		else $error("write to active register changed it");

	chk_new_ready: assert property ( // [RULE_13] [RULE_15]
		s_q.fsm == ccs_pkg::ST_WAIT && s_q.req != s_q.act &&
		src_ready(s_q.req.src, s_q.act.src, s_q.rdy_s2)
		|=> s_q.nrdy && s_q.sts[ccs_pkg::IRQ_SWITCH] && s_q.act == $past(s_q.act))
		else $error("ready oscillator did not raise new source ready");

	chk_wait_unready: assert property ( // [RULE_13]
		s_q.fsm == ccs_pkg::ST_WAIT && s_q.req != s_q.act &&
		!src_ready(s_q.req.src, s_q.act.src, s_q.rdy_s2)
		|=> !s_q.nrdy && $stable(s_q.act))
		else $error("switch went ahead without a ready oscillator");

endmodule
`default_nettype wire

// ===== ccs_pkg.sv
`default_nettype none
package ccs_pkg;
	// Register indexes; the byte address is four times the index.
	localparam logic [29:0] IDX_REQ = 30'h0000_0ED3;
	localparam logic [29:0] IDX_ACT = 30'h0000_0ED4;
	localparam logic [29:0] IDX_CTRL = 30'h0000_0ED5;
	localparam logic [29:0] IDX_RDY = 30'h0000_0ED6;
	localparam logic [29:0] IDX_OSC_MANUAL_ENABLE = 30'h0000_0ED7;
	localparam logic [29:0] IDX_TUNE = 30'h0000_0ED8;
	localparam logic [29:0] IDX_FRQ = 30'h0000_0ED9;
	localparam logic [29:0] IDX_STS = 30'h0000_0EDA;
	localparam logic [29:0] IDX_MSK = 30'h0000_0EDB;
	localparam logic [2:0] SRC_EXT = 3'h7;
	localparam logic [2:0] SRC_FAST = 3'h6;
	localparam logic [2:0] SRC_SLOW = 3'h5;
	localparam logic [2:0] SRC_SEC = 3'h4;
	localparam logic [2:0] SRC_PLL = 3'h2;
	localparam logic [2:0] CFG_FAST64 = 3'h0;
	localparam logic [3:0] DIV_ONE = 4'h0;
	localparam logic [3:0] DIV_FOUR = 4'h2;
	localparam logic [3:0] DIV_MAX = 4'h9;
	localparam logic [3:0] FRQ_64MHZ = 4'h8;
	localparam logic [3:0] FRQ_4MHZ = 4'h2;
	localparam int RDY_EXT = 7;
	localparam int RDY_FAST = 6;
	localparam int RDY_SLOW = 4;
	localparam int RDY_SEC = 3;
	localparam int RDY_PLL = 0;
	localparam logic [7:0] OSC_MANUAL_ENABLE_MASK = 8'hFC;
	localparam logic [7:0] RDY_MASK = 8'hFD;
	localparam int TUNE_W = 6;
	localparam int FRQ_W = 4;
	localparam int IRQ_W = 2;
	localparam int IRQ_SWITCH = 0;
	localparam int IRQ_REJECT = 1;
	localparam logic [9:0] RATIO_ONE = 10'h001;
	typedef struct packed {
		logic rsv;
		logic [2:0] src;
		logic [3:0] div;
	} ccs_clk_sel_t;
	typedef struct packed {
		logic hold;
		logic spwr;
		logic rsv5;
		logic done;
		logic nrdy;
		logic [2:0] rsv;
	} ccs_ctrl_t;
	typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_WAIT, ST_READY} ccs_fsm_t;
	typedef struct packed {
		ccs_fsm_t fsm;
		logic [1:0] init_cnt;
		logic [2:0] cfg_s1;
		logic [2:0] cfg_s2;
		logic allow_s1;
		logic allow_s2;
		logic [7:0] rdy_s1;
		logic [7:0] rdy_s2;
		ccs_clk_sel_t req;
		ccs_clk_sel_t act;
		logic hold;
		logic spwr;
		logic nrdy;
		logic done;
		logic [7:0] osc_en;
		logic [TUNE_W-1:0] tune;
		logic [FRQ_W-1:0] frq;
		logic [IRQ_W-1:0] sts;
		logic [IRQ_W-1:0] msk;
		logic irq;
		logic [9:0] ratio;
		logic wr_pend;
		logic rd_pend;
		logic [29:0] addr;
		logic [31:0] rdata;
		logic ready;
	} ccs_state_t;
	localparam ccs_state_t STATE_RST = '{fsm: ST_INIT, spwr: 1'b1, ready: 1'b1,
		ratio: RATIO_ONE, default: '0};
endpackage
`default_nettype wire

// ===== ccs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [2:0] cfg = 3'h0;
	logic allow = 1'b1;
	logic [7:0] rdy = 8'hFF;
	logic [31:0] hrdata;
	logic hreadyout;
	logic irq;
	ccs_pkg::ccs_clk_sel_t sel;
	logic [9:0] ratio;
	logic [7:0] oen;
	logic [ccs_pkg::TUNE_W-1:0] tune;
	logic [ccs_pkg::FRQ_W-1:0] frq;
	logic spwr;
	logic hresp;
	int err_count = 0;
	int checks_done = 0;
	int m_src;
	int m_div;
	int s;
	int d;
	logic [31:0] rd;
	always #50 hclk = ~hclk;
	ccs_clock_select dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.reset_source_cfg(cfg), .switch_allow_cfg(allow), .osc_ready(rdy),
		.sys_clk_sel(sel), .postscale_ratio(ratio), .osc_manual_enable(oen),
		.fast_osc_tune(tune), .fast_osc_freq_field(frq), .secondary_osc_high_power(spwr),
		.irq(irq));
	task automatic complete_run();
		if (err_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [31:0] sv(input int a, input int b);
		return 32'((a << 4) | b);
	endfunction
	// Samples the pre-edge value, so a registered hreadyout never races the bench.
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_count++;
			complete_run();
		end
	endtask
	task automatic bus(input logic w, input logic [29:0] idx, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {idx, 2'b00};
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic rd_chk(input string what, input logic [29:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0);
		check(what, exp, rd);
	endtask
	task automatic do_reset(input logic [2:0] c);
		hresetn <= 1'b0;
		cfg <= c;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (6) @(posedge hclk);
	endtask
	task automatic chk_state();
		int n;
		n = 0;
		while ({24'h0, sel} !== sv(m_src, m_div) && n < 20) begin
			@(posedge hclk);
			n++;
		end
		check("sys_clk_sel", sv(m_src, m_div), {24'h0, sel});
		check("postscale_ratio", 32'h1 << m_div, {22'h0, ratio});
		rd_chk("request", ccs_pkg::IDX_REQ, sv(m_src, m_div));
		rd_chk("active", ccs_pkg::IDX_ACT, sv(m_src, m_div));
	endtask
	initial begin
		repeat (100000) @(posedge hclk);
		err_count++;
		complete_run();
	end
	initial begin
		void'($urandom(32'hA6EC37C5));
		for (int c = 0; c < 8; c++) begin
			do_reset(c[2:0]);
			m_src = (c == 0 || c == 1 || c == 3) ? 6 : c;
			m_div = (c == 6) ? 2 : 0;
			chk_state();
			rd_chk("freq", ccs_pkg::IDX_FRQ, (c == 0) ? 32'h8 : 32'h2);
			check("freq_out", (c == 0) ? 32'h8 : 32'h2, {28'h0, frq});
		end
		bus(1'b1, ccs_pkg::IDX_MSK, 32'h3);
		// Every source and divider code once, then random ones; bit 7 set must read back 0.
		for (int i = 0; i < 24; i++) begin
			s = (i < 8) ? i : $urandom_range(7, 0);
			d = (i < 16) ? i : $urandom_range(15, 0);
			bus(1'b1, ccs_pkg::IDX_REQ, sv(s, d) | 32'h80);
			// A reserved source code drops the whole write, divider included.
			if (s inside {2, 4, 5, 6, 7}) begin
				m_src = s;
				if (d < 10) begin
					m_div = d;
				end
			end
			chk_state();
		end
		bus(1'b1, ccs_pkg::IDX_ACT, 32'h25);
		chk_state();
		rd_chk("unmapped", 30'h100, 32'h0);
		rdy <= 8'($urandom());
		bus(1'b1, ccs_pkg::IDX_OSC_MANUAL_ENABLE, 32'hFF);
		bus(1'b1, ccs_pkg::IDX_TUNE, 32'hFF);
		bus(1'b1, ccs_pkg::IDX_FRQ, 32'h5);
		rd_chk("enable", ccs_pkg::IDX_OSC_MANUAL_ENABLE, {24'h0, ccs_pkg::OSC_MANUAL_ENABLE_MASK});
		rd_chk("tune", ccs_pkg::IDX_TUNE, 32'h3F);
		rd_chk("freq_wr", ccs_pkg::IDX_FRQ, 32'h5);
		rd_chk("ready", ccs_pkg::IDX_RDY, {24'h0, rdy & ccs_pkg::RDY_MASK});
		rdy <= 8'hFF;
		check("enable_out", {24'h0, ccs_pkg::OSC_MANUAL_ENABLE_MASK}, {24'h0, oen});
		check("tune_out", 32'h3F, {26'h0, tune});
		check("freq_out_wr", 32'h5, {28'h0, frq});
		check("spwr_out", 32'h1, {31'h0, spwr});
		check("hresp", 32'h0, {31'h0, hresp});
		allow <= 1'b0;
		repeat (4) @(posedge hclk);
		bus(1'b1, ccs_pkg::IDX_REQ, sv(7, 3));
		chk_state();
		allow <= 1'b1;
		repeat (4) @(posedge hclk);
		bus(1'b1, ccs_pkg::IDX_REQ, sv(6, 0));
		m_src = 6;
		m_div = 0;
		chk_state();
		rdy <= 8'hF7;
		bus(1'b1, ccs_pkg::IDX_REQ, sv(4, 1));
		repeat (8) @(posedge hclk);
		check("unready_sel", sv(6, 0), {24'h0, sel});
		rdy <= 8'hFF;
		m_src = 4;
		m_div = 1;
		chk_state();
		bus(1'b1, ccs_pkg::IDX_CTRL, 32'hC0);
		bus(1'b1, ccs_pkg::IDX_REQ, sv(6, 2));
		repeat (8) @(posedge hclk);
		check("held_sel", sv(4, 1), {24'h0, sel});
		rd_chk("ctrl", ccs_pkg::IDX_CTRL, 32'hC8);
		bus(1'b1, ccs_pkg::IDX_REQ, sv(4, 1));
		chk_state();
		bus(1'b1, ccs_pkg::IDX_REQ, sv(6, 2));
		bus(1'b1, ccs_pkg::IDX_CTRL, 32'h40);
		m_src = 6;
		m_div = 2;
		chk_state();
		check("irq_set", 32'h1, {31'h0, irq});
		rd_chk("status", ccs_pkg::IDX_STS, 32'h3);
		bus(1'b1, ccs_pkg::IDX_STS, 32'h3);
		repeat (2) @(posedge hclk);
		check("irq_clear", 32'h0, {31'h0, irq});
		rd_chk("status_clear", ccs_pkg::IDX_STS, 32'h0);
		bus(1'b1, ccs_pkg::IDX_MSK, 32'h0);
		bus(1'b1, ccs_pkg::IDX_REQ, sv(0, 2));
		repeat (2) @(posedge hclk);
		check("irq_masked", 32'h0, {31'h0, irq});
		bus(1'b1, ccs_pkg::IDX_MSK, 32'h2);
		repeat (2) @(posedge hclk);
		check("irq_unmasked", 32'h1, {31'h0, irq});
		chk_state();
		complete_run();
	end
endmodule
`default_nettype wire
